// file: include/gpc_regs.vh
// Purpose: Register map and constants for the pin control block
// Assumes: Register index times four gives the APB byte address
// Notes: Definitions only
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// Register indices
`define GPC_IDX_IO_SUPPLY 10'h00d
`define GPC_IDX_PIN_LEVEL 10'h00e
`define GPC_IDX_IN_EN 10'h00f
`define GPC_IDX_PIN0_CTL 10'h010

// Reset values
`define GPC_RST_IO_SUPPLY 8'h09
`define GPC_RST_IN_EN 8'hff
`define GPC_RST_PIN0_CTL 8'h00
`define GPC_RST_IO_HV 1'b0
`define GPC_RST_IO_MODE 2'h0

// Supply control fields
`define GPC_IO_HV_BIT 7
`define GPC_IO_OV_BIT 6
`define GPC_IO_MODE_HI 5
`define GPC_IO_MODE_LO 4
`define GPC_IO_RSVD 4'h9

// Pin 0 control fields
`define GPC_P0_SEL_HI 7
`define GPC_P0_SEL_LO 5
`define GPC_P0_SRC_HI 4
`define GPC_P0_SRC_LO 2
`define GPC_P0_VAL_BIT 1
`define GPC_P0_OE_BIT 0

// Output source codes
`define GPC_SRC_DEV 3'h4
`define GPC_SRC_RSVD 3'h5
`define GPC_SRC_TX0 3'h6
`define GPC_SRC_TX1 3'h7

`endif

// file: rtl/gpc_top.v
// Purpose: General-purpose pin control: supply select, pin snapshot, input enables, pin 0 output
// Assumes: APB slave on clk_sys_i; status inputs come from logic on the same clock
// Notes: One wait state on every APB access
//
// Overview of operation
// - With the override clear the detected level drives both supply controls, with it set the written values do.
// - Bit 7 picks 1.8V at 0 and 3.3V at 1 and reads the detected level while the override is clear.
// - Bits 5:4 use 00 for 1.8V and 11 for 3.3V and read the detected level while the override is clear.
// - The status register returns the synchronized level of each input-enabled pin, bit n for pin n; disabled pins read 0.
// - Each pin has an input enable at its bit position, all set after reset.
// - Bits 4:2 pick the output source: receive ports 0 to 3, device status, reserved, transmit ports 0 and 1.
// - A receive-port source forwards remote GPIO 0 to 3, lock, pass, frame valid or line valid.
// - Device status forwards the output value, OR of enabled locks, AND of enabled passes or frame sync.
// - A transmit source forwards AND pass, OR pass, frame valid, line valid, synchronized or its interrupt.
// - The output value bit supplies the pin level when the register-controlled value is selected.
// - The output enable bit switches the pin driver and resets to off.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs.vh"

module gpc_top (
  input wire clk_sys_i, // System clock, 25 MHz
  input wire arst_n_i, // Async reset, active low
  input wire psel_i, // APB select
  input wire penable_i, // APB enable
  input wire pwrite_i, // APB direction
  input wire [11:0] paddr_i, // APB byte address
  input wire [31:0] pwdata_i, // APB write data
  input wire [3:0] pstrb_i, // APB byte strobes
  output reg [31:0] prdata_o, // APB read data
  output reg pready_o, // APB ready
  output reg pslverr_o, // APB error
  input wire [7:0] pin_in_i, // Raw pin levels
  input wire io_detect_3v3_i, // Detected supply, 1 = 3.3V
  input wire [3:0] rx_port_en_i, // Receive port enables
  input wire [15:0] rx_remote_gpio_i, // Remote GPIO, 4 per port
  input wire [3:0] rx_lock_i, // Receive lock per port
  input wire [3:0] rx_pass_i, // Receive pass per port
  input wire [3:0] rx_frame_valid_i, // Receive frame valid
  input wire [3:0] rx_line_valid_i, // Receive line valid
  input wire frame_sync_i, // Frame sync signal
  input wire [1:0] tx_pass_and_i, // Transmit AND pass
  input wire [1:0] tx_pass_or_i, // Transmit OR pass
  input wire [1:0] tx_frame_valid_i, // Transmit frame valid
  input wire [1:0] tx_line_valid_i, // Transmit line valid
  input wire [1:0] tx_synced_i, // Multi-port synchronized
  input wire [1:0] tx_irq_i, // Transmit port interrupt
  output reg [7:0] pin_input_enable_o, // Per-pin input enables
  output reg pin0_out_o, // Pin 0 output level
  output reg pin0_oe_o, // Pin 0 output enable
  output reg io_high_voltage_select_o, // Effective 3.3V select
  output reg [1:0] io_supply_mode_o // Effective supply mode
);

  // Pick one bit out of four
  function sel4;
    input [3:0] v;
    input [1:0] i;
    begin
      sel4 = v[i];
    end
  endfunction

  // Registers
  reg io_high_voltage_select;
  reg io_supply_override;
  reg [1:0] io_supply_mode;
  reg [7:0] pin_input_enables;
  reg [2:0] pin0_output_select;
  reg [2:0] pin0_output_source;
  reg pin0_output_value;
  reg pin0_output_enable;

  // Synchronisers for pins and the voltage detector
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;
  reg det_meta;
  reg det_sync;

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      det_meta <= 1'b0;
      det_sync <= 1'b0;
    end else begin
      pin_meta <= pin_in_i;
      pin_sync <= pin_meta;
      det_meta <= io_detect_3v3_i;
      det_sync <= det_meta;
    end
  end

  // Disabled inputs read as low so a floating pin cannot toggle status
  wire [7:0] pin_level_snapshot;
  assign pin_level_snapshot = pin_sync & pin_input_enables;

  // Effective supply controls
  wire eff_hv;
  wire [1:0] eff_mode;
  assign eff_hv = io_supply_override ? io_high_voltage_select : det_sync;
  assign eff_mode = io_supply_override ? io_supply_mode : {det_sync, det_sync};

  // APB decode
  wire [9:0] reg_idx;
  wire addr_ok;
  wire hit_io;
  wire hit_lvl;
  wire hit_ien;
  wire hit_p0;
  wire mapped;
  wire access;
  wire wr_en;

  assign reg_idx = paddr_i[11:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0);
  assign hit_io = addr_ok && (reg_idx == `GPC_IDX_IO_SUPPLY);
  assign hit_lvl = addr_ok && (reg_idx == `GPC_IDX_PIN_LEVEL);
  assign hit_ien = addr_ok && (reg_idx == `GPC_IDX_IN_EN);
  assign hit_p0 = addr_ok && (reg_idx == `GPC_IDX_PIN0_CTL);
  assign mapped = hit_io | hit_lvl | hit_ien | hit_p0;
  assign access = psel_i && penable_i;
  // Writes land on the completing edge only; status is read-only
  assign wr_en = access && pready_o && pwrite_i && mapped && !hit_lvl && pstrb_i[0];

  // Read mux
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_io) begin
      rd_byte = {eff_hv, io_supply_override, eff_mode, `GPC_IO_RSVD};
    end else if (hit_lvl) begin
      rd_byte = pin_level_snapshot;
    end else if (hit_ien) begin
      rd_byte = pin_input_enables;
    end else if (hit_p0) begin
      rd_byte = {pin0_output_select, pin0_output_source, pin0_output_value, pin0_output_enable};
    end
  end

  // Bus answer: one wait state, then ready for a single cycle
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      if (access && !pready_o) begin
        pready_o <= 1'b1;
        pslverr_o <= !mapped || (pwrite_i && hit_lvl);
        prdata_o <= pwrite_i ? 32'h00000000 : {24'h000000, rd_byte};
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_high_voltage_select <= `GPC_RST_IO_HV;
      io_supply_override <= 1'b0;
      io_supply_mode <= `GPC_RST_IO_MODE;
      pin_input_enables <= `GPC_RST_IN_EN;
      pin0_output_select <= 3'h0;
      pin0_output_source <= 3'h0;
      pin0_output_value <= 1'b0;
      pin0_output_enable <= 1'b0;
    end else if (wr_en) begin
      if (hit_io) begin
        io_high_voltage_select <= pwdata_i[`GPC_IO_HV_BIT];
        io_supply_override <= pwdata_i[`GPC_IO_OV_BIT];
        io_supply_mode <= pwdata_i[`GPC_IO_MODE_HI:`GPC_IO_MODE_LO];
      end
      if (hit_ien) begin
        pin_input_enables <= pwdata_i[7:0];
      end
      if (hit_p0) begin
        pin0_output_select <= pwdata_i[`GPC_P0_SEL_HI:`GPC_P0_SEL_LO];
        pin0_output_source <= pwdata_i[`GPC_P0_SRC_HI:`GPC_P0_SRC_LO];
        pin0_output_value <= pwdata_i[`GPC_P0_VAL_BIT];
        pin0_output_enable <= pwdata_i[`GPC_P0_OE_BIT];
      end
    end
  end

  // Device-level status terms
  wire lock_or_enabled;
  wire pass_and_enabled;
  assign lock_or_enabled = |(rx_lock_i & rx_port_en_i);
  // Disabled ports count as passing so they do not hold the AND low
  assign pass_and_enabled = &(rx_pass_i | ~rx_port_en_i);

  // Receive-port source
  wire [1:0] rx_port;
  wire [3:0] rx_gpio_sel;
  reg rx_bit;
  assign rx_port = pin0_output_source[1:0];
  assign rx_gpio_sel = rx_remote_gpio_i[{rx_port, 2'b00} +: 4];

  always @* begin
    case (pin0_output_select)
      3'h0, 3'h1, 3'h2, 3'h3: rx_bit = sel4(rx_gpio_sel, pin0_output_select[1:0]);
      3'h4: rx_bit = sel4(rx_lock_i, rx_port);
      3'h5: rx_bit = sel4(rx_pass_i, rx_port);
      3'h6: rx_bit = sel4(rx_frame_valid_i, rx_port);
      3'h7: rx_bit = sel4(rx_line_valid_i, rx_port);
      default: rx_bit = 1'b0;
    endcase
  end

  // Device-status source; frame sync sits on the code after the AND pass
  reg dev_bit;
  always @* begin
    case (pin0_output_select)
      3'h0: dev_bit = pin0_output_value;
      3'h1: dev_bit = lock_or_enabled;
      3'h2: dev_bit = pass_and_enabled;
      3'h3: dev_bit = frame_sync_i;
      default: dev_bit = 1'b0;
    endcase
  end

  // Transmit-port source
  wire tx_port;
  reg tx_bit;
  assign tx_port = pin0_output_source[0];

  always @* begin
    case (pin0_output_select)
      3'h0: tx_bit = tx_pass_and_i[tx_port];
      3'h1: tx_bit = tx_pass_or_i[tx_port];
      3'h2: tx_bit = tx_frame_valid_i[tx_port];
      3'h3: tx_bit = tx_line_valid_i[tx_port];
      3'h4: tx_bit = tx_synced_i[tx_port];
      3'h5: tx_bit = tx_irq_i[tx_port];
      default: tx_bit = 1'b0;
    endcase
  end

  // Source mux
  reg next_pin0_out;
  always @* begin
    case (pin0_output_source)
      `GPC_SRC_DEV: next_pin0_out = dev_bit;
      `GPC_SRC_RSVD: next_pin0_out = 1'b0;
      `GPC_SRC_TX0, `GPC_SRC_TX1: next_pin0_out = tx_bit;
      default: next_pin0_out = rx_bit;
    endcase
  end

  // Registered outputs; one cycle behind the selected source
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin0_out_o <= 1'b0;
      pin0_oe_o <= 1'b0;
      pin_input_enable_o <= `GPC_RST_IN_EN;
      io_high_voltage_select_o <= 1'b0;
      io_supply_mode_o <= 2'h0;
    end else begin
      pin0_out_o <= next_pin0_out;
      pin0_oe_o <= pin0_output_enable;
      pin_input_enable_o <= pin_input_enables;
      io_high_voltage_select_o <= eff_hv;
      io_supply_mode_o <= eff_mode;
    end
  end

endmodule // gpc_top
`default_nettype wire

// file: sim/gpc_checker.sv
// Purpose: Port assertions for gpc_top
// Assumes: Writes land at the pready edge
// Notes: Shadow copies track written config
`timescale 1ns/10ps
`default_nettype none
module gpc_checker (
  input wire logic clk_sys_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pwrite_i, // Write
  input wire logic [11:0] paddr_i, // Address
  input wire logic [31:0] pwdata_i, // Data
  input wire logic [3:0] pstrb_i, // Strobes
  input wire logic pready_o, // Ready
  input wire logic io_detect_3v3_i, // Detector
  input wire logic pin0_out_o, // Level
  input wire logic pin0_oe_o, // Enable
  input wire logic io_high_voltage_select_o, // Select
  input wire logic [1:0] io_supply_mode_o // Mode
);
  logic ov;
  logic [7:0] ctl;
  wire wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ov <= 1'b0;
      ctl <= 8'h00;
    end else begin
      if (wr && paddr_i == 12'h034) ov <= pwdata_i[6];
      if (wr && paddr_i == 12'h040) ctl <= pwdata_i[7:0];
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_rdy_wait; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_rdy_pulse; pready_o |=> !pready_o; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_oe; pin0_oe_o == $past(ctl[0]); endproperty
  a_oe: assert property (p_oe) else $error("enable mismatch");
  property p_mode; !ov && !$past(ov) && !$past(ov, 2) |-> io_supply_mode_o == {2{io_high_voltage_select_o}}; endproperty
  a_mode: assert property (p_mode) else $error("mode apart from select");
  property p_hv; (!ov && $stable(io_detect_3v3_i))[*5] |-> io_high_voltage_select_o == io_detect_3v3_i; endproperty
  a_hv: assert property (p_hv) else $error("select ignores detector");
  property p_val; $past(ctl[7:2]) == 6'h04 |-> pin0_out_o == $past(ctl[1]); endproperty
  a_val: assert property (p_val) else $error("value not driven");
  property p_rsv; $past(ctl[4:2]) == 3'h5 |-> !pin0_out_o; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source high");
  property p_dev; $past(ctl[4:2]) == 3'h4 && $past(ctl[7:5]) > 3'h4 |-> !pin0_out_o; endproperty
  a_dev: assert property (p_dev) else $error("reserved select high");
endmodule // gpc_checker
bind gpc_top gpc_checker i_chk (.*);
`default_nettype wire

// file: sim/gpc_board.sv
// Purpose: Board logic on the eight pins
// Assumes: Pin 0 is shared with the block driver
// Notes: No contention model
`timescale 1ns/10ps
`default_nettype none
module gpc_board (
  input wire logic [7:0] level_i, // Board levels
  input wire logic pin0_out_i, // Block level
  input wire logic pin0_oe_i, // Block enable
  output logic [7:0] pin_o // Pin levels
);
  // Board yields pin 0 while the block drives it
  assign pin_o = {level_i[7:1], pin0_oe_i ? pin0_out_i : level_i[0]};
endmodule // gpc_board
`default_nettype wire

// file: sim/gpio_pin_io_control_bench.sv
// Purpose: Self-checking bench for gpc_top
// Assumes: APB answer comes before the run timeout
// Notes: Status inputs share one vector
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_io_control_bench;
  localparam logic [48:0] PAT = 49'h0_6d3a_9c5e_17b4;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, io_detect_3v3_i = 1'b0, er;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic [3:0] pstrb_i = 4'h0;
  logic [48:0] st = 49'h0;
  logic [7:0] level = 8'h00;
  int mismatches = 0, checked = 0, cyc = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, pin0_out_o, pin0_oe_o, io_high_voltage_select_o, frame_sync_i;
  wire [1:0] io_supply_mode_o, tx_pass_and_i, tx_pass_or_i, tx_frame_valid_i, tx_line_valid_i, tx_synced_i, tx_irq_i;
  wire [3:0] rx_port_en_i, rx_lock_i, rx_pass_i, rx_frame_valid_i, rx_line_valid_i;
  wire [15:0] rx_remote_gpio_i;
  wire [7:0] pin_in_i, pin_input_enable_o;
  assign {rx_port_en_i, rx_remote_gpio_i, rx_lock_i, rx_pass_i, rx_frame_valid_i, rx_line_valid_i, frame_sync_i,
    tx_pass_and_i, tx_pass_or_i, tx_frame_valid_i, tx_line_valid_i, tx_synced_i, tx_irq_i} = st;
  gpc_top i_dut (.*);
  gpc_board i_board (.level_i(level), .pin0_out_i(pin0_out_o), .pin0_oe_i(pin0_oe_o), .pin_o(pin_in_i));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // One idle cycle after each transfer keeps psel from two writes in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    pstrb_i <= s;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00, 4'hf);
    chk(rd, e);
  endtask
  function automatic logic expo(input logic [2:0] src, input logic [2:0] sel, input logic val);
    int p = src[1:0];
    if (!src[2]) case (sel)
      4: return rx_lock_i[p];
      5: return rx_pass_i[p];
      6: return rx_frame_valid_i[p];
      7: return rx_line_valid_i[p];
      default: return rx_remote_gpio_i[4*p+sel];
    endcase
    if (src == 3'h4) case (sel)
      0: return val;
      1: return |(rx_lock_i & rx_port_en_i);
      2: return &(rx_pass_i | ~rx_port_en_i);
      3: return frame_sync_i;
      default: return 1'b0;
    endcase
    if (src[1]) case (sel)
      0: return tx_pass_and_i[src[0]];
      1: return tx_pass_or_i[src[0]];
      2: return tx_frame_valid_i[src[0]];
      3: return tx_line_valid_i[src[0]];
      4: return tx_synced_i[src[0]];
      5: return tx_irq_i[src[0]];
    endcase
    return 1'b0;
  endfunction
  task automatic t_regs();
    level <= 8'ha5;
    wt(3);
    rdc(12'h034, 32'h09);
    rdc(12'h038, 32'ha5);
    rdc(12'h03c, 32'hff);
    rdc(12'h040, 32'h00);
    chk(pin_input_enable_o, 32'hff);
    apb(1'b1, 12'h03c, 8'h0f, 4'h1);
    rdc(12'h038, 32'h05);
    chk(pin_input_enable_o, 32'h0f);
    apb(1'b1, 12'h03c, 8'hff, 4'h1);
    apb(1'b1, 12'h038, 8'h00, 4'h1);
    chk(er, 32'h1);
    apb(1'b1, 12'h040, 8'hff, 4'h0);
    chk(er, 32'h0);
    rdc(12'h044, 32'h00);
    chk(er, 32'h1);
    rdc(12'h035, 32'h00);
    chk(er, 32'h1);
    rdc(12'h040, 32'h00);
  endtask
  task automatic t_supply();
    io_detect_3v3_i <= 1'b1;
    wt(5);
    rdc(12'h034, 32'hb9);
    chk({io_high_voltage_select_o, io_supply_mode_o}, 32'h7);
    apb(1'b1, 12'h034, 8'h50, 4'h1);
    rdc(12'h034, 32'h59);
    chk({io_high_voltage_select_o, io_supply_mode_o}, 32'h1);
    apb(1'b1, 12'h034, 8'h00, 4'h1);
    wt(1);
    chk({io_high_voltage_select_o, io_supply_mode_o}, 32'h7);
    io_detect_3v3_i <= 1'b0;
    wt(5);
    rdc(12'h034, 32'h09);
  endtask
  task automatic t_mux();
    for (int k = 0; k < 128; k++) begin
      st <= k[0] ? PAT : ~PAT;
      apb(1'b1, 12'h040, {k[6:4], k[3:1], k[0], 1'b1}, 4'h1);
      @(posedge clk_sys_i);
      chk(pin0_out_o, expo(k[3:1], k[6:4], k[0]));
      chk(pin0_oe_o, 32'h1);
    end
    apb(1'b1, 12'h040, 8'h00, 4'h1);
    wt(1);
    chk(pin0_oe_o, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk(pin0_oe_o, 32'h0);
    t_regs();
    t_supply();
    t_mux();
    stop_test();
  end
endmodule // gpio_pin_io_control_bench
`default_nettype wire
